// File: dv/fel_lamp_viewer.sv
// passive observer standing in for the operator watching one lamp
`timescale 1ns/1ps
module fel_lamp_viewer (
  input wire logic clock,
  input wire logic clr,
  input wire logic lamp,
  input wire logic ref_lamp,
  output int on_cnt,
  output int rise_cnt,
  output int diff_cnt
);
  logic prev_ff;

  // lit time, flash starts and disagreement with a second lamp over a window
  always_ff @(posedge clock) begin
    prev_ff <= lamp;
    if (clr) begin
      on_cnt <= 0;
      rise_cnt <= 0;
      diff_cnt <= 0;
    end else begin
      on_cnt <= on_cnt + int'(lamp);
      rise_cnt <= rise_cnt + int'(lamp && !prev_ff);
      diff_cnt <= diff_cnt + int'(lamp != ref_lamp);
    end
  end
endmodule

// File: dv/fel_lamps_assertions.sv
// concurrent checks on the lamp controller ports
`timescale 1ns/1ps
module fel_lamps_assertions #(
  parameter int unsigned FLASH_CYC = 64,
  parameter int unsigned N_CH = 4
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic pwrite,
  input wire logic [fel_pkg::ADDR_W-1:0] paddr,
  input wire logic [N_CH-1:0] ch_fault,
  input wire logic [N_CH*fel_pkg::INST_W-1:0] ch_in_status,
  input wire logic [N_CH-1:0] rate_high_det,
  input wire logic bus_traffic,
  input wire logic locate_cmd,
  input wire logic init_busy,
  input wire logic optic_present,
  input wire logic optic_supported,
  input wire logic optic_fault,
  input wire logic fault_lamp,
  input wire logic bus_activity_lamp,
  input wire logic setup_lamp,
  input wire logic [N_CH-1:0] channel_rate_high_lamp,
  input wire logic optic_slot_one_lamp,
  input wire logic optic_slot_two_lamp,
  input wire logic [N_CH-1:0] reclock_bypass,
  input wire logic [fel_pkg::INST_W-1:0] collective_input
);
  import fel_pkg::*;
  // long enough to outlast any locate hold or traffic tail
  localparam int QLIM = int'(10 * FLASH_CYC);
  logic [1:0] rdy_ff;
  logic rdy;
  logic [1:0] coll_now;
  int quiet_ff;

  // the internal reset synchroniser keeps outputs low for two edges after release
  assign rdy = (rdy_ff == 2'h3) && clk_en;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) rdy_ff <= 2'h0;
    else if (rdy_ff != 2'h3) rdy_ff <= rdy_ff + 2'h1;
  end

  // cycles since the last traffic, locate pulse or control write
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) quiet_ff <= 0;
    else if (bus_traffic || locate_cmd || (psel && pwrite && paddr == OFS_CTRL)) quiet_ff <= 0;
    else if (quiet_ff < QLIM) quiet_ff <= quiet_ff + 1;
  end

  // any absent wins, then any present, else unmonitored
  always_comb begin
    coll_now = FEL_IN_UNMON;
    for (int i = 0; i < N_CH; i++) begin
      if (ch_in_status[2*i+:2] == FEL_IN_ABSENT) coll_now = FEL_IN_ABSENT;
      else if (ch_in_status[2*i+:2] == FEL_IN_PRESENT && coll_now != FEL_IN_ABSENT)
        coll_now = FEL_IN_PRESENT;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);

  AST_RATE_HIGH: assert property (
    rdy |=> ((channel_rate_high_lamp ^ $past(rate_high_det)) & ~reclock_bypass) == '0)
    else $error("high-rate lamp does not follow detection");
  AST_FAULT_ON: assert property (
    rdy && (|ch_fault) |-> ##2 fault_lamp)
    else $error("fault lamp dark with a channel fault");
  AST_OPT_DARK: assert property (
    rdy && (!optic_present || optic_fault) |=> !optic_slot_one_lamp)
    else $error("optic lamp lit without a healthy module");
  AST_OPT_ON: assert property (
    rdy && optic_present && optic_supported && !optic_fault |=> optic_slot_one_lamp)
    else $error("optic lamp dark with a supported module");
  AST_OPT_TWO: assert property (
    !optic_slot_two_lamp)
    else $error("second optic lamp lit");
  AST_ACT_DARK: assert property (
    quiet_ff == QLIM |-> !bus_activity_lamp)
    else $error("activity lamp lit on a quiet bus");
  AST_SETUP_ON: assert property (
    rdy && init_busy && quiet_ff == QLIM |=> setup_lamp)
    else $error("setup lamp dark while initialising");
  AST_COLL: assert property (
    rdy |=> collective_input == $past(coll_now))
    else $error("collective input state wrong");
endmodule

// File: dv/front_edge_status_indicator_logic_tb_top.sv
// self-checking bench for the front-edge lamp controller
`timescale 1ns/1ps
module front_edge_status_indicator_logic_tb_top;
  import fel_pkg::*;
  localparam int FC = 64;
  logic clock, arst_n, clk_en, psel, penable, pwrite, pready, pslverr, irq, clr, err;
  logic [7:0] paddr, ch_in_status;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] ch_fault, ch_warn, rate_high_det, rate_mid_det, rate_low_det, reclock_bypass;
  logic [3:0] channel_rate_high_lamp, channel_rate_mid_lamp, channel_rate_low_lamp;
  logic bus_traffic, locate_cmd, init_busy, optic_present, optic_supported, optic_fault;
  logic fault_lamp, bus_activity_lamp, setup_lamp, optic_slot_one_lamp, optic_slot_two_lamp;
  logic [1:0] collective_input;
  logic [2:0] sel;
  int miscompares = 0, checks = 0, cyc = 0, seed, on_cnt, rise_cnt, diff_cnt;
  // pattern model: off, steady, flash, short flash, double flash
  int on_tab[5] = '{0, FC, FC / 2, FC / 8, FC / 4};
  int rise_tab[5] = '{0, 0, 1, 1, 2};
  wire logic [5:0] lv = {channel_rate_mid_lamp[0], channel_rate_high_lamp[0],
    optic_slot_one_lamp, setup_lamp, bus_activity_lamp, fault_lamp};

  fel_lamps #(.FLASH_CYC(FC), .N_CH(4)) dut (
    .clock, .arst_n, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .ch_fault, .ch_warn, .ch_in_status, .rate_high_det, .rate_mid_det,
    .rate_low_det, .bus_traffic, .locate_cmd, .init_busy, .optic_present, .optic_supported,
    .optic_fault, .fault_lamp, .bus_activity_lamp, .setup_lamp, .channel_rate_high_lamp,
    .channel_rate_mid_lamp, .channel_rate_low_lamp, .optic_slot_one_lamp,
    .optic_slot_two_lamp, .reclock_bypass, .collective_input, .irq);
  fel_lamp_viewer u_view (.clock, .clr, .lamp(lv[sel]), .ref_lamp(setup_lamp), .on_cnt,
    .rise_cnt, .diff_cnt);

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // hang guard: the whole run needs well under this
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      finish_test;
    end
  end

  task automatic finish_test;
    if (miscompares == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; waits for pready, takes data and error at that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    // only the cycle ceiling ends a wait on a slave that never answers
    while (pready !== 1'b1) begin
      @(posedge clock);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // watch one lamp for a full flash period and compare with the pattern model
  task automatic measure(input logic [2:0] s, input int k);
    @(posedge clock);
    sel <= s;
    repeat (20) @(posedge clock);
    clr <= 1'b1;
    @(posedge clock);
    clr <= 1'b0;
    repeat (FC) @(posedge clock);
    #1;
    chk(on_cnt, on_tab[k]);
    chk(rise_cnt, rise_tab[k]);
  endtask

  function automatic logic [1:0] coll_model(input logic [7:0] s);
    int na, np;
    na = 0;
    np = 0;
    for (int c = 0; c < 4; c++) begin
      na += int'(s[2*c+:2] == 2'h1);
      np += int'(s[2*c+:2] == 2'h2);
    end
    return na > 0 ? FEL_IN_ABSENT : (np > 0 ? FEL_IN_PRESENT : FEL_IN_UNMON);
  endfunction

  initial begin
    {psel, penable, pwrite, clr, bus_traffic, locate_cmd, init_busy, sel} = '0;
    {paddr, pwdata, ch_fault, ch_warn, rate_high_det, rate_mid_det, rate_low_det} = '0;
    {optic_present, optic_supported, optic_fault} = '0;
    ch_in_status = 8'haa;
    clk_en = 1'b1;
    arst_n = 1'b0;
    seed = 32'hc8f410ce;
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    repeat (4) @(posedge clock);
    apb(1'b0, OFS_MODE, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, OFS_IRQ_MASK, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    // every operating mode on all channels, ending in manual bypass
    for (int m = 0; m < 7; m++) begin
      apb(1'b1, OFS_MODE, {20'h0, {4{m[2:0]}}});
      apb(1'b0, OFS_MODE, 32'h0);
      chk(rd, {20'h0, {4{m[2:0]}}});
    end
    repeat (3) @(posedge clock);
    chk(reclock_bypass, 4'hf);
    chk(channel_rate_low_lamp, channel_rate_high_lamp);
    measure(3'h4, 2);
    measure(3'h5, 2);
    apb(1'b1, OFS_MODE, 32'h0);
    // random status in auto mode
    for (int i = 0; i < 40; i++) begin
      @(posedge clock);
      {rate_high_det, rate_mid_det, rate_low_det} <= 12'($random(seed));
      {optic_present, optic_supported, optic_fault} <= 3'($random(seed));
      for (int c = 0; c < 4; c++) ch_in_status[2*c+:2] <= 2'($unsigned($random(seed)) % 3);
      repeat (3) @(posedge clock);
      chk(channel_rate_high_lamp, rate_high_det);
      chk(channel_rate_mid_lamp, rate_mid_det);
      chk(channel_rate_low_lamp, rate_low_det);
      chk(collective_input, coll_model(ch_in_status));
      chk(optic_slot_two_lamp, 1'b0);
      if (!optic_present || optic_fault) chk(optic_slot_one_lamp, 1'b0);
      else if (optic_supported) chk(optic_slot_one_lamp, 1'b1);
    end
    ch_in_status <= 8'haa;
    {optic_present, optic_supported, optic_fault} <= 3'b100;
    measure(3'h3, 2);
    // warning on one channel, then a fault on another; interrupt masked first
    ch_warn <= 4'h4;
    measure(3'h0, 2);
    ch_fault <= 4'h2;
    measure(3'h0, 1);
    chk(irq, 1'b0);
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk(rd[EV_FAULT], 1'b1);
    apb(1'b1, OFS_IRQ_MASK, 32'h1 << EV_FAULT);
    repeat (3) @(posedge clock);
    chk(irq, 1'b1);
    apb(1'b1, OFS_IRQ_STAT, 32'hf);
    repeat (3) @(posedge clock);
    chk(irq, 1'b0);
    {ch_fault, ch_warn} <= 8'h0;
    measure(3'h0, 0);
    locate_cmd <= 1'b1;
    @(posedge clock);
    locate_cmd <= 1'b0;
    measure(3'h1, 4);
    chk(diff_cnt, 0);
    measure(3'h2, 4);
    repeat (600) @(posedge clock);
    bus_traffic <= 1'b1;
    measure(3'h1, 3);
    bus_traffic <= 1'b0;
    repeat (700) @(posedge clock);
    measure(3'h1, 0);
    init_busy <= 1'b1;
    measure(3'h2, 1);
    {optic_present, optic_supported, optic_fault} <= 3'b110;
    apb(1'b0, OFS_LAMPS, 32'h0);
    chk(rd, {15'h0, rate_low_det, rate_mid_det, rate_high_det, 5'h0c});
    init_busy <= 1'b0;
    repeat (200) @(posedge clock);
    measure(3'h2, 0);
    // software locate through the control register
    apb(1'b1, OFS_CTRL, 32'h1);
    measure(3'h1, 4);
    finish_test;
  end
endmodule

bind fel_lamps fel_lamps_assertions #(.FLASH_CYC(FLASH_CYC), .N_CH(N_CH)) u_chk (
  .clock, .arst_n, .clk_en, .psel, .pwrite, .paddr, .ch_fault, .ch_in_status, .rate_high_det,
  .bus_traffic, .locate_cmd, .init_busy, .optic_present, .optic_supported, .optic_fault,
  .fault_lamp, .bus_activity_lamp, .setup_lamp, .channel_rate_high_lamp, .optic_slot_one_lamp,
  .optic_slot_two_lamp, .reclock_bypass, .collective_input);

// File: hw/fel_blink_gen.sv
// free-running flash cadence generator for the front-edge lamps
`timescale 1ns/1ps
module fel_blink_gen #(
  parameter int unsigned PERIOD = fel_pkg::FLASH_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  output logic flash_ff,
  output logic short_ff,
  output logic double_ff,
  output logic tick_ff
);
  import fel_pkg::*;

  localparam int unsigned CW = $clog2(PERIOD + 1);
  localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);
  localparam logic [CW-1:0] HALF = CW'(PERIOD / 2);
  localparam logic [CW-1:0] SLOT = CW'((PERIOD / SHORT_DIV) > 0 ? PERIOD / SHORT_DIV : 1);

  logic [CW-1:0] cnt_ff;

  // phase counter wraps once per flash period
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else if (clk_en) begin
      cnt_ff <= (cnt_ff >= LAST) ? '0 : cnt_ff + 1'b1;
    end
  end

  // patterns are decoded from the phase and registered so lamps never glitch
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flash_ff <= 1'b0;
      short_ff <= 1'b0;
      double_ff <= 1'b0;
      tick_ff <= 1'b0;
    end else if (clk_en) begin
      flash_ff <= cnt_ff < HALF;
      short_ff <= cnt_ff < SLOT;
      double_ff <= (cnt_ff < SLOT) || (cnt_ff >= 2 * SLOT && cnt_ff < 3 * SLOT);
      tick_ff <= cnt_ff >= LAST;
    end
  end
endmodule

// File: hw/fel_lamps.sv
// front-edge indicator lamp controller with apb register access
//
// Operation
// - fault lamp dark on pass, steady on internal fault, flashing on warning.
// - fault lamp shows one state combined over all four channels.
// - bus activity lamp dark while no bus traffic is seen.
// - bus traffic gives a continuous train of short flashes.
// - a locate command makes the bus activity lamp double-flash.
// - on locate the setup lamp double-flashes in step with activity lamp.
// - setup lamp lit during init or mode change, dark otherwise.
// - high-rate lamp steady when the channel input is detected at 3G.
// - high-rate lamp dark when the channel input is not 3G.
// - mid-rate lamp steady when input detected at HD, dark otherwise.
// - low-rate lamp steady when input detected at SD, dark otherwise.
// - in manual bypass modes the three rate lamps flash instead.
// - optic slot one dark when no submodule fitted or it reports a fault.
// - optic slot one steady when a supported submodule is fitted.
// - optic slot one flashes when the fitted submodule is unsupported.
// - optic slot two lamp is unused and held dark.
// - collective input: absent if any absent, else present if any, else unmonitored.
// - manual bypass modes always bypass the reclocker, equalizer stays on.
`timescale 1ns/1ps
module fel_lamps #(
  parameter int unsigned FLASH_CYC = fel_pkg::FLASH_CYC,
  parameter int unsigned N_CH = fel_pkg::NUM_CH
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fel_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // status sources
  input wire logic [N_CH-1:0] ch_fault,
  input wire logic [N_CH-1:0] ch_warn,
  input wire logic [N_CH*fel_pkg::INST_W-1:0] ch_in_status,
  input wire logic [N_CH-1:0] rate_high_det,
  input wire logic [N_CH-1:0] rate_mid_det,
  input wire logic [N_CH-1:0] rate_low_det,
  input wire logic bus_traffic,
  input wire logic locate_cmd,
  input wire logic init_busy,
  input wire logic optic_present,
  input wire logic optic_supported,
  input wire logic optic_fault,
  // lamps and controls
  output logic fault_lamp,
  output logic bus_activity_lamp,
  output logic setup_lamp,
  output logic [N_CH-1:0] channel_rate_high_lamp,
  output logic [N_CH-1:0] channel_rate_mid_lamp,
  output logic [N_CH-1:0] channel_rate_low_lamp,
  output logic optic_slot_one_lamp,
  output logic optic_slot_two_lamp,
  output logic [N_CH-1:0] reclock_bypass,
  output logic [fel_pkg::INST_W-1:0] collective_input,
  output logic irq
);
  import fel_pkg::*;

  // activity lamp sequencer, one-hot
  typedef enum logic [2:0] {
    FEL_ACT_IDLE = 3'b001,
    FEL_ACT_BUSY = 3'b010,
    FEL_ACT_LOCATE = 3'b100
  } fel_act_type;

  // true for both manual bypass settings
  function automatic logic is_man_bypass(input logic [MODE_W-1:0] m);
    is_man_bypass = (m == FEL_MAN_BYP_HD) || (m == FEL_MAN_BYP_SD);
  endfunction

  // reload-or-decrement helper for the period hold counters
  function automatic logic [PCNT_W-1:0] hold_next(input logic [PCNT_W-1:0] cur, input logic load,
    input logic [PCNT_W-1:0] val, input logic tick);
    if (load) begin
      hold_next = val;
    end else if (tick && cur != '0) begin
      hold_next = cur - 1'b1;
    end else begin
      hold_next = cur;
    end
  endfunction

  localparam logic [PCNT_W-1:0] ACT_LOAD = PCNT_W'(ACT_PERIODS);
  localparam logic [PCNT_W-1:0] LOC_LOAD = PCNT_W'(LOCATE_PERIODS);
  localparam logic [PCNT_W-1:0] CFG_LOAD = PCNT_W'(CFG_PERIODS);

  logic rst_s1_ff;
  logic rst_n;
  logic blink_flash;
  logic blink_short;
  logic blink_double;
  logic period_tick;
  logic [N_CH*MODE_W-1:0] mode_ff;
  logic [IRQ_W-1:0] irq_stat_ff;
  logic [IRQ_W-1:0] irq_mask_ff;
  logic [31:0] prdata_ff;
  logic [PCNT_W-1:0] act_hold_ff;
  logic [PCNT_W-1:0] loc_hold_ff;
  logic [PCNT_W-1:0] cfg_hold_ff;
  fel_act_type act_state_ff;
  fel_act_type nxt_act_state;
  logic any_fault_ff;
  logic any_warn_ff;
  logic absent_ff;
  logic [INST_W-1:0] nxt_coll;
  logic wr_en;
  logic setup_ph;
  logic addr_ok;
  logic locate_sw;
  logic locate_any;
  logic mode_wr;
  logic [IRQ_W-1:0] ev;
  logic [31:0] rd_mux;

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_ff <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n <= rst_s1_ff;
    end
  end

  fel_blink_gen #(
    .PERIOD(FLASH_CYC)
  ) u_blink (
    .clock(clock),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .flash_ff(blink_flash),
    .short_ff(blink_short),
    .double_ff(blink_double),
    .tick_ff(period_tick)
  );

  // apb decode; zero wait states, unmapped addresses answer with pslverr
  assign setup_ph = psel && !penable;
  assign wr_en = psel && penable && pwrite && addr_ok && clk_en;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign prdata = prdata_ff;
  assign locate_sw = wr_en && paddr == OFS_CTRL && pwdata[CTRL_LOCATE_BIT];
  assign locate_any = locate_sw || locate_cmd;
  assign mode_wr = wr_en && paddr == OFS_MODE;

  always_comb begin
    case (paddr)
      OFS_CTRL, OFS_MODE, OFS_STATUS, OFS_IRQ_STAT, OFS_IRQ_MASK, OFS_LAMPS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // read mux; control bit of ctrl reads back as zero since it is a strobe
  always_comb begin
    rd_mux = '0;
    case (paddr)
      OFS_MODE: rd_mux[N_CH*MODE_W-1:0] = mode_ff;
      OFS_STATUS: begin
        rd_mux[ST_COLL_LSB +: INST_W] = collective_input;
        rd_mux[ST_INIT_BIT] = init_busy;
        rd_mux[ST_CFG_BIT] = cfg_hold_ff != '0;
        rd_mux[ST_OPT_LSB] = optic_present;
        rd_mux[ST_OPT_LSB + 1] = optic_supported;
        rd_mux[ST_OPT_LSB + 2] = optic_fault;
      end
      OFS_IRQ_STAT: rd_mux[IRQ_W-1:0] = irq_stat_ff;
      OFS_IRQ_MASK: rd_mux[IRQ_W-1:0] = irq_mask_ff;
      OFS_LAMPS: rd_mux[3*N_CH+4:0] = {channel_rate_low_lamp, channel_rate_mid_lamp,
                           channel_rate_high_lamp, optic_slot_two_lamp, optic_slot_one_lamp,
                           setup_lamp, bus_activity_lamp, fault_lamp};
      default: rd_mux = '0;
    endcase
  end

  // read data captured in the setup cycle so it is a flop in the access cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata_ff <= '0;
    end else if (clk_en && setup_ph) begin
      prdata_ff <= rd_mux;
    end
  end

  // per-channel operating mode, written by software
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_ff <= {N_CH{MODE_RST}};
    end else if (mode_wr) begin
      mode_ff <= pwdata[N_CH*MODE_W-1:0];
    end
  end

  // interrupt mask register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask_ff <= IRQ_MASK_RST;
    end else if (wr_en && paddr == OFS_IRQ_MASK) begin
      irq_mask_ff <= pwdata[IRQ_W-1:0];
    end
  end

  // collective state over all channels, registered
  always_comb begin
    nxt_coll = FEL_IN_UNMON;
    for (int i = 0; i < N_CH; i++) begin
      if (ch_in_status[i*INST_W +: INST_W] == FEL_IN_PRESENT) begin
        nxt_coll = FEL_IN_PRESENT;
      end
    end
    for (int i = 0; i < N_CH; i++) begin
      if (ch_in_status[i*INST_W +: INST_W] == FEL_IN_ABSENT) begin
        nxt_coll = FEL_IN_ABSENT;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      collective_input <= FEL_IN_UNMON;
      any_fault_ff <= 1'b0;
      any_warn_ff <= 1'b0;
      absent_ff <= 1'b0;
    end else if (clk_en) begin
      collective_input <= nxt_coll;
      any_fault_ff <= |ch_fault;
      any_warn_ff <= |ch_warn;
      absent_ff <= nxt_coll == FEL_IN_ABSENT;
    end
  end

  // events are rising edges of the collective conditions plus locate
  assign ev[EV_FAULT] = (|ch_fault) && !any_fault_ff;
  assign ev[EV_WARN] = (|ch_warn) && !any_warn_ff;
  assign ev[EV_LOCATE] = locate_any;
  assign ev[EV_NOINPUT] = (nxt_coll == FEL_IN_ABSENT) && !absent_ff;

  // sticky status, write one to clear; a new event in the clear cycle wins
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_ff <= '0;
    end else if (clk_en) begin
      if (wr_en && paddr == OFS_IRQ_STAT) begin
        irq_stat_ff <= (irq_stat_ff & ~pwdata[IRQ_W-1:0]) | ev;
      end else begin
        irq_stat_ff <= irq_stat_ff | ev;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  // hold counters measured in flash periods; keeps counters small at 40 MHz
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      act_hold_ff <= '0;
      loc_hold_ff <= '0;
      cfg_hold_ff <= '0;
    end else if (clk_en) begin
      act_hold_ff <= hold_next(act_hold_ff, bus_traffic, ACT_LOAD, period_tick);
      loc_hold_ff <= hold_next(loc_hold_ff, locate_any, LOC_LOAD, period_tick);
      cfg_hold_ff <= hold_next(cfg_hold_ff, mode_wr, CFG_LOAD, period_tick);
    end
  end

  // activity sequencer: locate outranks plain traffic from every state
  always_comb begin
    case (act_state_ff)
      FEL_ACT_IDLE, FEL_ACT_BUSY, FEL_ACT_LOCATE: begin
        if (loc_hold_ff != '0) begin
          nxt_act_state = FEL_ACT_LOCATE;
        end else if (act_hold_ff != '0) begin
          nxt_act_state = FEL_ACT_BUSY;
        end else begin
          nxt_act_state = FEL_ACT_IDLE;
        end
      end
      default: nxt_act_state = FEL_ACT_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      act_state_ff <= FEL_ACT_IDLE;
    end else if (clk_en) begin
      act_state_ff <= nxt_act_state;
    end
  end

  // status lamps; both locate lamps read the same double pattern so they stay in step
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fault_lamp <= 1'b0;
      bus_activity_lamp <= 1'b0;
      setup_lamp <= 1'b0;
    end else if (clk_en) begin
      fault_lamp <= any_fault_ff || (any_warn_ff && blink_flash);
      case (act_state_ff)
        FEL_ACT_LOCATE: bus_activity_lamp <= blink_double;
        FEL_ACT_BUSY: bus_activity_lamp <= blink_short;
        default: bus_activity_lamp <= 1'b0;
      endcase
      setup_lamp <= (act_state_ff == FEL_ACT_LOCATE) ? blink_double :
                    init_busy || cfg_hold_ff != '0;
    end
  end

  // per-channel rate lamps and reclocker bypass
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      channel_rate_high_lamp <= '0;
      channel_rate_mid_lamp <= '0;
      channel_rate_low_lamp <= '0;
      reclock_bypass <= '0;
    end else if (clk_en) begin
      for (int i = 0; i < N_CH; i++) begin
        if (is_man_bypass(mode_ff[i*MODE_W +: MODE_W])) begin
          channel_rate_high_lamp[i] <= blink_flash;
          channel_rate_mid_lamp[i] <= blink_flash;
          channel_rate_low_lamp[i] <= blink_flash;
          reclock_bypass[i] <= 1'b1;
        end else begin
          channel_rate_high_lamp[i] <= rate_high_det[i];
          channel_rate_mid_lamp[i] <= rate_mid_det[i];
          channel_rate_low_lamp[i] <= rate_low_det[i];
          // auto bypass drops the reclocker when no known rate is seen
          reclock_bypass[i] <= mode_ff[i*MODE_W +: MODE_W] == FEL_AUTO_BYPASS &&
                               !(rate_high_det[i] || rate_mid_det[i] || rate_low_det[i]);
        end
      end
    end
  end

  // optic slot lamps; a fault overrides the type check
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      optic_slot_one_lamp <= 1'b0;
      optic_slot_two_lamp <= 1'b0;
    end else if (clk_en) begin
      if (!optic_present || optic_fault) begin
        optic_slot_one_lamp <= 1'b0;
      end else if (optic_supported) begin
        optic_slot_one_lamp <= 1'b1;
      end else begin
        optic_slot_one_lamp <= blink_flash;
      end
      optic_slot_two_lamp <= 1'b0;
    end
  end
endmodule

// File: hw/fel_pkg.sv
// constants and types shared by the front-edge lamp logic
package fel_pkg;
  // clock and flash timing
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned FLASH_PERIOD_MS = 500;
  localparam int unsigned FLASH_CYC = (CLK_HZ / 1000) * FLASH_PERIOD_MS;
  localparam int unsigned SHORT_DIV = 8;
  localparam int unsigned ACT_PERIODS = 2;
  localparam int unsigned LOCATE_PERIODS = 8;
  localparam int unsigned CFG_PERIODS = 2;
  localparam int unsigned PCNT_W = 4;
  // channel layout
  localparam int unsigned NUM_CH = 4;
  localparam int unsigned MODE_W = 3;
  localparam int unsigned INST_W = 2;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFS_LAMPS = 8'h14;
  localparam int unsigned ADDR_W = 8;
  // field positions
  localparam int unsigned CTRL_LOCATE_BIT = 0;
  localparam int unsigned ST_COLL_LSB = 0;
  localparam int unsigned ST_INIT_BIT = 2;
  localparam int unsigned ST_CFG_BIT = 3;
  localparam int unsigned ST_OPT_LSB = 4;
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned EV_FAULT = 0;
  localparam int unsigned EV_WARN = 1;
  localparam int unsigned EV_LOCATE = 2;
  localparam int unsigned EV_NOINPUT = 3;
  localparam logic [MODE_W-1:0] MODE_RST = 3'h0;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

  // per-channel input operating mode
  typedef enum logic [MODE_W-1:0] {
    FEL_AUTO_BYPASS = 3'h0,
    FEL_AUTO_MUTE = 3'h1,
    FEL_FIX_3G = 3'h2,
    FEL_FIX_HD = 3'h3,
    FEL_FIX_SD = 3'h4,
    FEL_MAN_BYP_HD = 3'h5,
    FEL_MAN_BYP_SD = 3'h6
  } fel_mode_type;

  // per-channel and collective input status
  typedef enum logic [INST_W-1:0] {
    FEL_IN_UNMON = 2'h0,
    FEL_IN_ABSENT = 2'h1,
    FEL_IN_PRESENT = 2'h2
  } fel_instat_type;
endpackage
